// *** vim_pkg.sv ***
package vim_pkg;

    localparam int unsigned DIN_W  = 8;
    localparam int unsigned DOUT_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 4;

    // register indices on the parameter port
    localparam logic [ADDR_W-1:0] ADDR_IN_MASK   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OUT_MASK  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_VIRT_IN   = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_VIRT_OUT  = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_TERM_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_OUT_STAT  = 4'h5;

    // largest value accepted by each writable register
    localparam logic [DATA_W-1:0] MAX_IN_VAL  = 16'h00FF;
    localparam logic [DATA_W-1:0] MAX_OUT_VAL = 16'h000F;

    localparam logic [DIN_W-1:0]  RST_IN_MASK  = 8'h00;
    localparam logic [DOUT_W-1:0] RST_OUT_MASK = 4'h0;
    localparam logic [DIN_W-1:0]  RST_VIRT_IN  = 8'h00;
    localparam logic [DOUT_W-1:0] RST_VIRT_OUT = 4'h0;

    // selected input byte positions with a fixed meaning
    localparam int unsigned BIT_RUN       = 0;
    localparam int unsigned BIT_REVERSE   = 1;
    localparam int unsigned BIT_EXT_FAULT = 5;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } vim_req_t;

    typedef struct packed {
        logic              valid;
        logic              err;
        logic [DATA_W-1:0] data;
    } vim_rsp_t;

endpackage

// *** vim_sync.sv ***
`timescale 1ns/1ps
module vim_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            meta_r <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// *** vim_bitmux.sv ***
`timescale 1ns/1ps
module vim_bitmux #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] i_phys,
    input  wire logic [WIDTH-1:0] i_virt,
    input  wire logic [WIDTH-1:0] i_mask,
    output logic      [WIDTH-1:0] o_sel
);
    // one switch per bit, no bit sees another
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_bit
            assign o_sel[b] = (i_phys[b] & ~i_mask[b]) | (i_virt[b] & i_mask[b]);
        end
    endgenerate
endmodule

// *** vim_mask_mux.sv ***
`timescale 1ns/1ps
// Overview of operation
// - select = (phys AND NOT mask) OR (virt AND mask)
// - mask 0 picks terminal (drive function on outputs), 1 picks virtual
// - each mask bit drives one switch only
// - input mask eight bits, values 0..255
// - output mask four bits, values 0..15
// - terminals and virtual bits mix freely
// - all input functions usable from virtual bits
// - virtual 1 forward, 3 reverse, 0 stop
// - masked output follows virtual output bit
// - unmasked input keeps following its terminal
// - masks and virtual values readable and writable
module vim_mask_mux (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst_n,
    input  wire vim_pkg::vim_req_t             i_req,
    output vim_pkg::vim_rsp_t                  o_rsp,
    input  wire logic [vim_pkg::DIN_W-1:0]     i_term_in,
    input  wire logic [vim_pkg::DOUT_W-1:0]    i_drive_fn,
    output logic      [vim_pkg::DIN_W-1:0]     o_sel_in,
    output logic      [vim_pkg::DOUT_W-1:0]    o_term_out,
    output logic                               o_run_fwd,
    output logic                               o_run_rev,
    output logic                               o_ext_fault
);
    import vim_pkg::*;

    logic [DIN_W-1:0]  term_sync;
    logic [DIN_W-1:0]  imask_r;
    logic [DIN_W-1:0]  imask_nxt;
    logic [DOUT_W-1:0] omask_r;
    logic [DOUT_W-1:0] omask_nxt;
    logic [DIN_W-1:0]  vin_r;
    logic [DIN_W-1:0]  vin_nxt;
    logic [DOUT_W-1:0] vout_r;
    logic [DOUT_W-1:0] vout_nxt;
    logic [DIN_W-1:0]  sel_in_nxt;
    logic [DOUT_W-1:0] sel_out_nxt;
    logic              wr_ok;
    logic              wr_bad;
    logic              rd_bad;
    logic [DATA_W-1:0] rd_data;
    vim_rsp_t          rsp_nxt;

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a <= ADDR_OUT_STAT);
    endfunction

    function automatic logic addr_writable(input logic [ADDR_W-1:0] a);
        addr_writable = (a <= ADDR_VIRT_OUT);
    endfunction

    // wide inputs share one limit, narrow ones another
    function automatic logic value_fits(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        if ((a == ADDR_IN_MASK) || (a == ADDR_VIRT_IN))
        begin
            value_fits = (d <= MAX_IN_VAL);
        end
        else
        begin
            value_fits = (d <= MAX_OUT_VAL);
        end
    endfunction

    // terminals are asynchronous pins
    vim_sync #(
        .WIDTH (DIN_W)
    ) u_term_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (i_term_in),
        .o_sync  (term_sync)
    );

    // out-of-range values and read-only targets are refused whole
    assign wr_ok  = i_req.wr && addr_writable(i_req.addr) && value_fits(i_req.addr, i_req.data);
    assign wr_bad = i_req.wr && !wr_ok;
    assign rd_bad = i_req.rd && !addr_mapped(i_req.addr);

    // next values feed the muxes so a write shows one cycle later
    assign imask_nxt = (wr_ok && i_req.addr == ADDR_IN_MASK)  ? i_req.data[DIN_W-1:0]  : imask_r;
    assign omask_nxt = (wr_ok && i_req.addr == ADDR_OUT_MASK) ? i_req.data[DOUT_W-1:0] : omask_r;
    assign vin_nxt   = (wr_ok && i_req.addr == ADDR_VIRT_IN)  ? i_req.data[DIN_W-1:0]  : vin_r;
    assign vout_nxt  = (wr_ok && i_req.addr == ADDR_VIRT_OUT) ? i_req.data[DOUT_W-1:0] : vout_r;

    // terminals mixed with virtual bits on the input byte
    vim_bitmux #(
        .WIDTH (DIN_W)
    ) u_in_mux (
        .i_phys (term_sync),
        .i_virt (vin_nxt),
        .i_mask (imask_nxt),
        .o_sel  (sel_in_nxt)
    );

    // drive functions mixed with virtual control on the outputs
    vim_bitmux #(
        .WIDTH (DOUT_W)
    ) u_out_mux (
        .i_phys (i_drive_fn),
        .i_virt (vout_nxt),
        .i_mask (omask_nxt),
        .o_sel  (sel_out_nxt)
    );

    assign rd_data = (i_req.addr == ADDR_IN_MASK)   ? {{(DATA_W-DIN_W){1'b0}}, imask_r} :
                     (i_req.addr == ADDR_OUT_MASK)  ? {{(DATA_W-DOUT_W){1'b0}}, omask_r} :
                     (i_req.addr == ADDR_VIRT_IN)   ? {{(DATA_W-DIN_W){1'b0}}, vin_r} :
                     (i_req.addr == ADDR_VIRT_OUT)  ? {{(DATA_W-DOUT_W){1'b0}}, vout_r} :
                     (i_req.addr == ADDR_TERM_STAT) ? {{(DATA_W-DIN_W){1'b0}}, term_sync} :
                     (i_req.addr == ADDR_OUT_STAT)  ? {{(DATA_W-DOUT_W){1'b0}}, o_term_out} :
                     16'h0000;

    assign rsp_nxt.valid = i_req.wr || i_req.rd;
    assign rsp_nxt.err   = wr_bad || rd_bad;
    assign rsp_nxt.data  = (i_req.rd && !rd_bad) ? rd_data : 16'h0000;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            imask_r <= RST_IN_MASK;
            omask_r <= RST_OUT_MASK;
            vin_r   <= RST_VIRT_IN;
            vout_r  <= RST_VIRT_OUT;
        end
        else
        begin
            imask_r <= imask_nxt;
            omask_r <= omask_nxt;
            vin_r   <= vin_nxt;
            vout_r  <= vout_nxt;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_rsp       <= '0;
            o_sel_in    <= '0;
            o_term_out  <= '0;
            o_run_fwd   <= 1'b0;
            o_run_rev   <= 1'b0;
            o_ext_fault <= 1'b0;
        end
        else
        begin
            o_rsp       <= rsp_nxt;
            o_sel_in    <= sel_in_nxt;
            o_term_out  <= sel_out_nxt;
            o_run_fwd   <= sel_in_nxt[BIT_RUN] && !sel_in_nxt[BIT_REVERSE];
            o_run_rev   <= sel_in_nxt[BIT_RUN] && sel_in_nxt[BIT_REVERSE];
            o_ext_fault <= !sel_in_nxt[BIT_EXT_FAULT];
        end
    end

    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    logic past_run;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            past_run <= 1'b0;
        end
        else
        begin
            past_run <= 1'b1;
        end
    end

    sequence s_wr_in_mask_bad;
        i_req.wr && i_req.addr == ADDR_IN_MASK && i_req.data > MAX_IN_VAL;
    endsequence

    sequence s_wr_out_mask_bad;
        i_req.wr && i_req.addr == ADDR_OUT_MASK && i_req.data > MAX_OUT_VAL;
    endsequence

    sequence s_wr_virt_in_ok;
        i_req.wr && i_req.addr == ADDR_VIRT_IN && i_req.data <= MAX_IN_VAL;
    endsequence

    sequence s_rd_in_mask;
        i_req.rd && !i_req.wr && i_req.addr == ADDR_IN_MASK;
    endsequence

    sequence s_wr_in_mask_ok;
        i_req.wr && i_req.addr == ADDR_IN_MASK && i_req.data <= MAX_IN_VAL;
    endsequence

    sequence s_wr_out_mask_ok;
        i_req.wr && i_req.addr == ADDR_OUT_MASK && i_req.data <= MAX_OUT_VAL;
    endsequence

    sequence s_wr_virt_out_ok;
        i_req.wr && i_req.addr == ADDR_VIRT_OUT && i_req.data <= MAX_OUT_VAL;
    endsequence

    sequence s_wr_read_only;
        i_req.wr && (i_req.addr == ADDR_TERM_STAT || i_req.addr == ADDR_OUT_STAT);
    endsequence

    sequence s_rd_unmapped;
        i_req.rd && !i_req.wr && i_req.addr > ADDR_OUT_STAT;
    endsequence

    sequence s_any_access;
        i_req.wr || i_req.rd;
    endsequence

    chk_in_select_formula: assert property (
        past_run |-> o_sel_in == (($past(term_sync) & ~imask_r) | (vin_r & imask_r)))
        else $error("input byte does not match mask formula");

    chk_out_select_formula: assert property (
        past_run |-> o_term_out == (($past(i_drive_fn) & ~omask_r) | (vout_r & omask_r)))
        else $error("output bits do not match mask formula");

    chk_full_mask_virtual: assert property (
        (past_run && imask_r == 8'hFF) |-> o_sel_in == vin_r)
        else $error("full input mask did not select virtual byte");

    chk_bit_isolation: assert property (
        (past_run && imask_r[0] && !imask_r[1]) |-> (o_sel_in[0] == vin_r[0] && o_sel_in[1] == $past(term_sync[1])))
        else $error("neighbouring mask bits interact");

    chk_in_mask_range: assert property (
        s_wr_in_mask_bad |=> o_rsp.err && imask_r == $past(imask_r))
        else $error("oversized input mask accepted");

    chk_out_mask_range: assert property (
        s_wr_out_mask_bad |=> o_rsp.err && omask_r == $past(omask_r))
        else $error("oversized output mask accepted");

    chk_run_decode: assert property (
        past_run |-> (o_run_fwd == (o_sel_in[1:0] == 2'b01) && o_run_rev == (o_sel_in[1:0] == 2'b11)))
        else $error("run direction decode wrong");

    chk_virtual_out_follow: assert property (
        past_run |-> (o_term_out & omask_r) == (vout_r & omask_r))
        else $error("masked output not following virtual word");

    chk_terminal_follow: assert property (
        past_run |-> (o_sel_in & ~imask_r) == ($past(term_sync) & ~imask_r))
        else $error("unmasked input not following terminal");

    chk_mask_readback: assert property (
        s_rd_in_mask |=> o_rsp.valid && !o_rsp.err && o_rsp.data == {8'h00, $past(imask_r)})
        else $error("input mask readback wrong");

    chk_write_next_cycle: assert property (
        s_wr_virt_in_ok ##1 (imask_r == 8'hFF) |-> o_sel_in == $past(i_req.data[7:0]))
        else $error("virtual input write not visible next cycle");

    chk_reset_masks: assert property (
        $rose(past_run) |-> imask_r == 8'h00 && omask_r == 4'h0 && o_sel_in == 8'h00)
        else $error("masks not zero after reset");

    chk_rsp_strobe: assert property (
        s_any_access |=> o_rsp.valid)
        else $error("access not answered next cycle");

    chk_rsp_quiet: assert property (
        !(i_req.wr || i_req.rd) |=> !o_rsp.valid)
        else $error("answer strobe without access");

    chk_read_only_refused: assert property (
        s_wr_read_only |=> o_rsp.valid && o_rsp.err)
        else $error("write to status register not refused");

    chk_unmapped_read: assert property (
        s_rd_unmapped |=> o_rsp.err && o_rsp.data == 16'h0000)
        else $error("unmapped read not refused");

    chk_in_mask_write: assert property (
        s_wr_in_mask_ok |=> imask_r == $past(i_req.data[7:0]))
        else $error("legal input mask not stored");

    chk_out_mask_write: assert property (
        s_wr_out_mask_ok |=> omask_r == $past(i_req.data[3:0]))
        else $error("legal output mask not stored");

    chk_virt_in_write: assert property (
        s_wr_virt_in_ok |=> vin_r == $past(i_req.data[7:0]))
        else $error("virtual input byte not stored");

    chk_virt_out_write: assert property (
        s_wr_virt_out_ok |=> vout_r == $past(i_req.data[3:0]))
        else $error("virtual output word not stored");

    chk_zero_mask_terminal: assert property (
        (past_run && imask_r == 8'h00) |-> o_sel_in == $past(term_sync))
        else $error("clear input mask did not select terminals");

    chk_out_bit_isolation: assert property (
        (past_run && omask_r[1] && !omask_r[0]) |-> (o_term_out[1] == vout_r[1] && o_term_out[0] == $past(i_drive_fn[0])))
        else $error("neighbouring output mask bits interact");

    chk_ext_fault_level: assert property (
        past_run |-> o_ext_fault == !o_sel_in[BIT_EXT_FAULT])
        else $error("external fault does not follow selected bit");

    chk_stop_decode: assert property (
        (past_run && !o_sel_in[BIT_RUN]) |-> !o_run_fwd && !o_run_rev)
        else $error("drive runs without run bit");

endmodule

// *** vim_master.sv ***
`timescale 1ns/1ps
module vim_master (
    input  wire logic              i_clock,
    output vim_pkg::vim_req_t      o_req,
    input  wire vim_pkg::vim_rsp_t i_rsp
);
    import vim_pkg::*;

    initial o_req = '0;

    // one access: request stands one cycle, answer taken one edge after acceptance
    task automatic access(input logic wr, input logic rd, input logic [ADDR_W-1:0] addr,
                          input logic [DATA_W-1:0] data, output vim_rsp_t rsp);
        @(posedge i_clock);
        o_req <= '{wr: wr, rd: rd, addr: addr, data: data};
        @(posedge i_clock);
        // released lines show the inverse so stale values never look valid
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
        // answer stands until this edge; take it before the edge replaces it
        @(posedge i_clock);
        rsp = i_rsp;
    endtask

    // value written is the sum of the weights of the enabled bits
    task automatic write_bits(input logic [ADDR_W-1:0] addr, input logic [7:0] bits,
                              output vim_rsp_t rsp);
        logic [DATA_W-1:0] sum;
        sum = '0;
        for (int n = 0; n < 8; n++)
            if (bits[n])
                sum = sum + (16'h0001 << n);
        access(1'b1, 1'b0, addr, sum, rsp);
    endtask
endmodule

// *** virtual_io_mask_mux_tb.sv ***
`timescale 1ns/1ps
module virtual_io_mask_mux_tb;
    import vim_pkg::*;

    localparam int TIMEOUT = 2000;

    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    vim_req_t          req;
    vim_rsp_t          rsp;
    logic [DIN_W-1:0]  term_in = 8'h00;
    logic [DOUT_W-1:0] drive_fn = 4'h0;
    logic [DIN_W-1:0]  sel_in;
    logic [DOUT_W-1:0] term_out;
    logic              run_fwd;
    logic              run_rev;
    logic              ext_fault;
    int                err_total = 0;
    int                num_checks = 0;
    int                cycles = 0;

    always #50 clock = ~clock;

    vim_mask_mux i_dut (.i_clock(clock), .i_rst_n(rst_n), .i_req(req), .o_rsp(rsp),
        .i_term_in(term_in), .i_drive_fn(drive_fn), .o_sel_in(sel_in), .o_term_out(term_out),
        .o_run_fwd(run_fwd), .o_run_rev(run_rev), .o_ext_fault(ext_fault));

    vim_master i_master (.i_clock(clock), .o_req(req), .i_rsp(rsp));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT)
        begin
            err_total++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one register access, checks the answer code and, for reads, the data
    task automatic acc(input logic wr, input logic rd, input logic [3:0] a, input logic [15:0] d,
                       input logic exp_err, input logic [15:0] exp_d);
        vim_rsp_t r;
        i_master.access(wr, rd, a, d, r);
        chk({14'h0000, r.valid, r.err}, {14'h0000, 1'b1, exp_err});
        if (rd)
            chk(r.data, exp_d);
    endtask

    task automatic set_mask(input logic [3:0] a, input logic [7:0] bits);
        vim_rsp_t r;
        i_master.write_bits(a, bits, r);
        chk({15'h0000, r.err}, 16'h0000);
    endtask

    task automatic t_reset;
        chk({8'h00, sel_in}, 16'h0000);
        // no terminal voltage on input bit 5 reads as an external fault
        chk({9'h000, term_out, run_fwd, run_rev, ext_fault}, 16'h0001);
        for (int a = 0; a < 4; a++)
            acc(1'b0, 1'b1, 4'(a), 16'h0000, 1'b0, 16'h0000);
    endtask

    task automatic t_route;
        logic [7:0] im [4] = '{8'h00, 8'hFF, 8'h0F, 8'h81};
        logic [3:0] om [3] = '{4'h0, 4'hF, 4'h2};
        logic [7:0] exp_b;
        @(posedge clock);
        term_in <= 8'hA5;
        drive_fn <= 4'h9;
        repeat (4) @(posedge clock);
        acc(1'b1, 1'b0, ADDR_VIRT_IN, 16'h001C, 1'b0, 16'h0000);
        acc(1'b1, 1'b0, ADDR_VIRT_OUT, 16'h0006, 1'b0, 16'h0000);
        foreach (im[i])
        begin
            set_mask(ADDR_IN_MASK, im[i]);
            exp_b = (8'hA5 & ~im[i]) | (8'h1C & im[i]);
            chk({8'h00, sel_in}, {8'h00, exp_b});
            chk({15'h0000, ext_fault}, {15'h0000, ~exp_b[5]});
        end
        // a virtual write under a full mask reaches the byte one cycle later
        set_mask(ADDR_IN_MASK, 8'hFF);
        acc(1'b1, 1'b0, ADDR_VIRT_IN, 16'h005A, 1'b0, 16'h0000);
        chk({8'h00, sel_in}, 16'h005A);
        foreach (om[i])
        begin
            set_mask(ADDR_OUT_MASK, {4'h0, om[i]});
            chk({12'h000, term_out}, {12'h000, (4'h9 & ~om[i]) | (4'h6 & om[i])});
        end
        acc(1'b0, 1'b1, ADDR_TERM_STAT, 16'h0000, 1'b0, 16'h00A5);
        acc(1'b0, 1'b1, ADDR_OUT_STAT, 16'h0000, 1'b0, 16'h000B);
    endtask

    task automatic t_range;
        acc(1'b1, 1'b0, ADDR_IN_MASK, MAX_IN_VAL, 1'b0, 16'h0000);
        acc(1'b1, 1'b0, ADDR_IN_MASK, 16'h0100, 1'b1, 16'h0000);
        acc(1'b0, 1'b1, ADDR_IN_MASK, 16'h0000, 1'b0, 16'h00FF);
        acc(1'b1, 1'b0, ADDR_OUT_MASK, 16'h0010, 1'b1, 16'h0000);
        acc(1'b1, 1'b0, ADDR_OUT_MASK, MAX_OUT_VAL, 1'b0, 16'h0000);
        acc(1'b0, 1'b1, ADDR_OUT_MASK, 16'h0000, 1'b0, 16'h000F);
        acc(1'b1, 1'b0, ADDR_TERM_STAT, 16'h0001, 1'b1, 16'h0000);
        acc(1'b0, 1'b1, 4'h6, 16'h0000, 1'b1, 16'h0000);
    endtask

    task automatic t_run;
        logic [7:0] vin [3] = '{8'h01, 8'h03, 8'h00};
        logic [1:0] exp [3] = '{2'b10, 2'b01, 2'b00};
        @(posedge clock);
        term_in <= 8'h20;
        set_mask(ADDR_IN_MASK, 8'h03);
        repeat (4) @(posedge clock);
        foreach (vin[i])
        begin
            acc(1'b1, 1'b0, ADDR_VIRT_IN, {8'h00, vin[i]}, 1'b0, 16'h0000);
            chk({14'h0000, run_fwd, run_rev}, {14'h0000, exp[i]});
        end
        chk({15'h0000, ext_fault}, 16'h0000);
        acc(1'b1, 1'b0, ADDR_VIRT_IN, 16'h0020, 1'b0, 16'h0000);
        @(posedge clock);
        term_in <= 8'h00;
        repeat (4) @(posedge clock);
        #1;
        chk({15'h0000, ext_fault}, 16'h0001);
    endtask

    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        t_reset();
        t_route();
        t_range();
        t_run();
        wrap_up();
    end
endmodule
